// file: hw/drive_mode_and_homing_control.sv
// Function
// - Command word bit 8 high applies the stop behaviour chosen by the halt stop selection.
// - Halt selection 1 decelerates the motor normally to standstill.
// - Halt selection 2 stops the motor with urgent deceleration outside homing mode; in homing mode it decelerates normally.
// - A detected fault removes motor excitation so the motor coasts, the only fault reaction 0.
// - The control mode comes from the mode selection, codes 1,3,4,6,7, reset 1.
// - The mode in effect is reported read-only in the readback object with the same codes.
// - Once homing finds its reference the actual position is loaded with the home offset.
// - In homing mode with halt clear, bit 4 rising starts homing, high keeps it, falling aborts.
// - In homing mode halt stops the axis with the homing acceleration instead of homing.
// - In homing mode, status bit 10 shows home reached with halt clear, and zero velocity with halt set.
// - Status bit 12 is 0 until homing completes and 1 after successful completion.
// - Status bit 13 flags failed homing and a readable error code gives the cause.
// - The homing method object takes 1-14, 17-22, 23-30 and 33-35 and resets to 1.
// - Limit switches, reference switch and index pulse all serve as homing references.
// - The home offset is a signed 32-bit distance from the reference to position zero.
// - The speed pair holds switch-search speed (reset 5000) and zero-search speed (reset 100).
`include "drive_mode_params.svh"
`default_nettype none
module drive_mode_and_homing_control
   import drive_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire obj_req_t objReq,
   output obj_rsp_t objRsp,
   input wire logic [15:0] ctrlWord,
   input wire logic faultDetect,
   input wire logic velocityZero,
   input wire logic posLimit,
   input wire logic negLimit,
   input wire logic refSwitch,
   input wire logic indexPulse,
   output logic [15:0] statusBits,
   output logic [7:0] modeActive,
   output motion_cmd_t motionCmd,
   output logic posLoad,
   output logic signed [31:0] posLoadValue,
   output logic [15:0] homeErrCode
);
   logic [15:0] haltSel_reg;
   logic [15:0] faultSel_reg;
   logic [7:0] modeSel_reg;
   logic signed [31:0] homeOfs_reg;
   logic [7:0] method_reg;
   logic signed [31:0] speedSwitch_reg;
   logic signed [31:0] speedZero_reg;
   logic signed [31:0] ramp_reg;
   logic startPrev_reg;
   home_state_t homeState_reg;
   home_state_t homeState_next;
   logic [15:0] errCode_next;
   wire logic haltBit = ctrlWord[`CW_HALT];
   wire logic startBit = ctrlWord[`CW_HOME_START];
   wire logic inHoming = (modeActive == `MODE_HOME);
   wire logic startRise = startBit && !startPrev_reg;
   wire logic startFall = !startBit && startPrev_reg;
   wire logic homingBusy = (homeState_reg == HOME_SWITCH) || (homeState_reg == HOME_ZERO);
   function automatic logic modeValid(input logic [7:0] m);
      return (m == `MODE_PP) || (m == `MODE_PV) || (m == `MODE_PT) ||
             (m == `MODE_HOME) || (m == `MODE_IP);
   endfunction : modeValid
   function automatic logic methodValid(input logic [7:0] m);
      return ((m >= 8'h01) && (m <= 8'h0e)) || ((m >= 8'h11) && (m <= 8'h1e)) ||
             ((m >= 8'h21) && (m <= 8'h23));
   endfunction : methodValid
   function automatic logic methodNegative(input logic [7:0] m);
      return (m == 8'h01) || (m == 8'h03) || (m == 8'h05) || ((m >= 8'h0b) && (m <= 8'h0e)) ||
             (m == 8'h11) || (m == 8'h13) || (m == 8'h15) || ((m >= 8'h1b) && (m <= 8'h1e)) ||
             (m == 8'h21);
   endfunction : methodNegative
   // Reference switch for the switch-search phase of each method
   function automatic logic switchSeen(input logic [7:0] m, input logic pl, input logic nl,
                                       input logic rs);
      if (m == 8'h01 || m == 8'h11) begin
         return nl;
      end else if (m == 8'h02 || m == 8'h12) begin
         return pl;
      end else begin
         return rs;
      end
   endfunction : switchSeen
   wire logic limitMethod = (method_reg == 8'h01) || (method_reg == 8'h02) ||
                            (method_reg == 8'h11) || (method_reg == 8'h12);
   wire logic wrongLimit = limitMethod ?
                           (methodNegative(method_reg) ? posLimit : negLimit) :
                           (posLimit || negLimit);
   logic wrOk;
   always_comb begin
      wrOk = 1'b0;
      case (objReq.index)
         `IDX_HALT_SEL: wrOk = (objReq.data[15:0] == `HALT_DECEL) ||
                               (objReq.data[15:0] == `HALT_URGENT);
         `IDX_FAULT_SEL: wrOk = (objReq.data[15:0] == `FAULT_COAST);
         `IDX_MODE_SEL: wrOk = modeValid(objReq.data[7:0]);
         `IDX_HOME_OFS: wrOk = 1'b1;
         `IDX_METHOD: wrOk = methodValid(objReq.data[7:0]);
         `IDX_SPEEDS: wrOk = (objReq.sub == `SUB_SWITCH) || (objReq.sub == `SUB_ZERO);
         `IDX_RAMP: wrOk = 1'b1;
         default: wrOk = 1'b0;
      endcase
   end
   wire logic doWrite = objReq.write && wrOk;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         haltSel_reg <= `RST_HALT_SEL;
         faultSel_reg <= `RST_FAULT_SEL;
         modeSel_reg <= `RST_MODE;
         homeOfs_reg <= `RST_HOME_OFS;
         method_reg <= `RST_METHOD;
         speedSwitch_reg <= `RST_SPEED_SWITCH;
         speedZero_reg <= `RST_SPEED_ZERO;
         ramp_reg <= `RST_RAMP;
      end else if (doWrite) begin
         case (objReq.index)
            `IDX_HALT_SEL: haltSel_reg <= objReq.data[15:0];
            `IDX_FAULT_SEL: faultSel_reg <= objReq.data[15:0];
            `IDX_MODE_SEL: modeSel_reg <= objReq.data[7:0];
            `IDX_HOME_OFS: homeOfs_reg <= objReq.data;
            `IDX_METHOD: method_reg <= objReq.data[7:0];
            `IDX_SPEEDS: begin
               if (objReq.sub == `SUB_SWITCH) begin
                  speedSwitch_reg <= objReq.data;
               end else begin
                  speedZero_reg <= objReq.data;
               end
            end
            `IDX_RAMP: ramp_reg <= objReq.data;
            default: ;
         endcase
      end
   end
   // Read mux and write answers, one cycle after the request
   logic [31:0] rdData;
   always_comb begin
      rdData = 32'h0000_0000;
      case (objReq.index)
         `IDX_HALT_SEL: rdData = {16'h0000, haltSel_reg};
         `IDX_FAULT_SEL: rdData = {16'h0000, faultSel_reg};
         `IDX_MODE_SEL: rdData = {24'h00_0000, modeSel_reg};
         `IDX_MODE_RB: rdData = {24'h00_0000, modeActive};
         `IDX_HOME_OFS: rdData = homeOfs_reg;
         `IDX_METHOD: rdData = {24'h00_0000, method_reg};
         `IDX_SPEEDS: rdData = (objReq.sub == `SUB_SWITCH) ? speedSwitch_reg :
                               (objReq.sub == `SUB_ZERO) ? speedZero_reg : `SPEED_ENTRIES;
         `IDX_RAMP: rdData = ramp_reg;
         default: rdData = 32'h0000_0000;
      endcase
   end
   wire logic rdKnown = (objReq.index == `IDX_HALT_SEL) || (objReq.index == `IDX_FAULT_SEL) ||
                        (objReq.index == `IDX_MODE_SEL) || (objReq.index == `IDX_MODE_RB) ||
                        (objReq.index == `IDX_HOME_OFS) || (objReq.index == `IDX_METHOD) ||
                        (objReq.index == `IDX_SPEEDS) || (objReq.index == `IDX_RAMP);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         objRsp <= '0;
      end else begin
         objRsp.ack <= objReq.write || objReq.read;
         objRsp.reject <= (objReq.write && !wrOk) || (!objReq.write && objReq.read && !rdKnown);
         objRsp.data <= (objReq.read && !objReq.write) ? rdData : 32'h0000_0000;
      end
   end
   // Mode change waits until no homing run is moving the axis
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeActive <= `RST_MODE;
      end else if (!homingBusy) begin
         modeActive <= modeSel_reg;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         startPrev_reg <= 1'b0;
      end else begin
         startPrev_reg <= startBit;
      end
   end
   always_comb begin
      homeState_next = homeState_reg;
      errCode_next = homeErrCode;
      case (homeState_reg)
         HOME_IDLE, HOME_DONE, HOME_FAIL, HOME_HALT: begin
            if (inHoming && startRise && !haltBit) begin
               errCode_next = `HERR_NONE;
               if (method_reg == 8'h23) begin
                  homeState_next = HOME_DONE;
               end else if (method_reg == 8'h21 || method_reg == 8'h22) begin
                  homeState_next = HOME_ZERO;
               end else begin
                  homeState_next = HOME_SWITCH;
               end
            end else if (startFall && homeState_reg == HOME_HALT) begin
               homeState_next = HOME_IDLE;
            end
         end
         HOME_SWITCH: begin
            if (haltBit) begin
               homeState_next = HOME_HALT;
            end else if (startFall || !inHoming) begin
               homeState_next = HOME_IDLE;
            end else if (switchSeen(method_reg, posLimit, negLimit, refSwitch)) begin
               homeState_next = (method_reg <= 8'h0e) ? HOME_ZERO : HOME_DONE;
            end else if (wrongLimit) begin
               homeState_next = HOME_FAIL;
               errCode_next = `HERR_LIMIT_IN_SEARCH;
            end
         end
         HOME_ZERO: begin
            if (haltBit) begin
               homeState_next = HOME_HALT;
            end else if (startFall || !inHoming) begin
               homeState_next = HOME_IDLE;
            end else if (indexPulse) begin
               homeState_next = HOME_DONE;
            end else if (!limitMethod && (posLimit || negLimit)) begin
               homeState_next = HOME_FAIL;
               errCode_next = `HERR_LIMIT_IN_ZERO;
            end
         end
         default: homeState_next = HOME_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         homeState_reg <= HOME_IDLE;
         homeErrCode <= `HERR_NONE;
      end else begin
         homeState_reg <= homeState_next;
         homeErrCode <= errCode_next;
      end
   end
   // Load actual position with the offset on reference found
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         posLoad <= 1'b0;
         posLoadValue <= `RST_HOME_OFS;
      end else begin
         posLoad <= (homeState_next == HOME_DONE) && (homeState_reg != HOME_DONE);
         posLoadValue <= homeOfs_reg;
      end
   end
   // Stop arbitration: fault outranks halt, halt outranks homing motion
   stop_kind_t stopNext;
   always_comb begin
      stopNext = STOP_NONE;
      if (faultDetect) begin
         stopNext = STOP_COAST;
      end else if (haltBit) begin
         // Halt selection; unset value 0 falls back to normal decel
         stopNext = (haltSel_reg == `HALT_URGENT && !inHoming) ? STOP_URGENT : STOP_DECEL;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         motionCmd <= '0;
      end else begin
         motionCmd.stop <= stopNext;
         motionCmd.homingMove <= (homeState_next == HOME_SWITCH) ||
                                 (homeState_next == HOME_ZERO);
         motionCmd.dirNegative <= methodNegative(method_reg);
         motionCmd.speed <= (homeState_next == HOME_ZERO) ? speedZero_reg : speedSwitch_reg;
         motionCmd.ramp <= ramp_reg;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         statusBits <= 16'h0000;
      end else begin
         statusBits <= 16'h0000;
         if (inHoming) begin
            statusBits[`SW_TARGET] <= haltBit ? velocityZero : (homeState_next == HOME_DONE);
         end
         statusBits[`SW_ATTAINED] <= (homeState_next == HOME_DONE);
         statusBits[`SW_HOME_ERR] <= (homeState_next == HOME_FAIL);
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence homingStarted;
      inHoming && startRise && !haltBit && method_reg != 8'h23 && homeState_reg == HOME_IDLE;
   endsequence

   fault_coast_a: assert property (faultDetect |=> motionCmd.stop == STOP_COAST)
      else $error("fault did not coast");
   halt_urgent_a: assert property (!faultDetect && haltBit && !inHoming &&
      haltSel_reg == `HALT_URGENT |=> motionCmd.stop == STOP_URGENT)
      else $error("urgent halt missing");
   halt_decel_a: assert property (!faultDetect && haltBit && haltSel_reg == `HALT_DECEL
      |=> motionCmd.stop == STOP_DECEL)
      else $error("normal halt missing");
   reject_keep_a: assert property (objReq.write && objReq.index == `IDX_MODE_SEL &&
      !modeValid(objReq.data[7:0]) |=> $stable(modeSel_reg) && objRsp.reject)
      else $error("bad mode write stored");
   mode_follow_a: assert property (!homingBusy && !$stable(modeSel_reg)
      |=> modeActive == $past(modeSel_reg))
      else $error("readback lags selection");
   home_start_a: assert property (homingStarted |=> homingBusy)
      else $error("homing did not start");
   home_abort_a: assert property (homingBusy && startFall && !haltBit
      |=> homeState_reg == HOME_IDLE)
      else $error("homing not aborted");
   home_halt_a: assert property (homingBusy && haltBit |=> homeState_reg == HOME_HALT
      ##0 !motionCmd.homingMove)
      else $error("halt did not stop homing");
   pos_load_a: assert property ($rose(homeState_reg == HOME_DONE)
      |-> posLoad && posLoadValue == $past(homeOfs_reg))
      else $error("position not loaded");
   attained_a: assert property (homeState_reg == HOME_DONE
      |-> statusBits[`SW_ATTAINED] && !statusBits[`SW_HOME_ERR])
      else $error("attained flag wrong");
   fail_flag_a: assert property (homeState_reg == HOME_FAIL
      |-> statusBits[`SW_HOME_ERR] && homeErrCode != `HERR_NONE)
      else $error("homing error not flagged");
   target_halt_a: assert property (inHoming && haltBit && modeActive == `MODE_HOME
      ##1 $stable(modeActive) |-> statusBits[`SW_TARGET] == $past(velocityZero))
      else $error("target bit wrong under halt");
endmodule : drive_mode_and_homing_control
`default_nettype wire

// file: hw/drive_mode_params.svh
`ifndef DRIVE_MODE_PARAMS_SVH
`define DRIVE_MODE_PARAMS_SVH
// Object indices
`define IDX_HALT_SEL 16'h605d
`define IDX_FAULT_SEL 16'h605e
`define IDX_MODE_SEL 16'h6060
`define IDX_MODE_RB 16'h6061
`define IDX_HOME_OFS 16'h607c
`define IDX_METHOD 16'h6098
`define IDX_SPEEDS 16'h6099
`define IDX_RAMP 16'h609a
// Sub-indices of the speed pair
`define SUB_COUNT 8'h00
`define SUB_SWITCH 8'h01
`define SUB_ZERO 8'h02
`define SPEED_ENTRIES 32'h0000_0002
// Reset values
`define RST_HALT_SEL 16'h0000
`define RST_FAULT_SEL 16'h0000
`define RST_MODE 8'h01
`define RST_METHOD 8'h01
`define RST_HOME_OFS 32'h0000_0000
`define RST_SPEED_SWITCH 32'h0000_1388
`define RST_SPEED_ZERO 32'h0000_0064
`define RST_RAMP 32'h0001_86a0
// Command and status word bit positions
`define CW_HOME_START 4
`define CW_HALT 8
`define SW_TARGET 10
`define SW_ATTAINED 12
`define SW_HOME_ERR 13
// Mode encodings
`define MODE_PP 8'h01
`define MODE_PV 8'h03
`define MODE_PT 8'h04
`define MODE_HOME 8'h06
`define MODE_IP 8'h07
// Halt and fault selections
`define HALT_DECEL 16'h0001
`define HALT_URGENT 16'h0002
`define FAULT_COAST 16'h0000
// Homing error causes
`define HERR_NONE 16'h0000
`define HERR_LIMIT_IN_SEARCH 16'h0001
`define HERR_LIMIT_IN_ZERO 16'h0002
`endif

// file: hw/drive_mode_pkg.sv
`default_nettype none
package drive_mode_pkg;
   typedef enum logic [1:0] {
      STOP_NONE = 2'b00,
      STOP_DECEL = 2'b01,
      STOP_URGENT = 2'b10,
      STOP_COAST = 2'b11
   } stop_kind_t;

   typedef enum logic [2:0] {
      HOME_IDLE = 3'b000,
      HOME_SWITCH = 3'b001,
      HOME_ZERO = 3'b010,
      HOME_DONE = 3'b011,
      HOME_FAIL = 3'b100,
      HOME_HALT = 3'b101
   } home_state_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] data;
   } obj_req_t;

   typedef struct packed {
      logic ack;
      logic reject;
      logic [31:0] data;
   } obj_rsp_t;

   typedef struct packed {
      stop_kind_t stop;
      logic homingMove;
      logic dirNegative;
      logic [31:0] speed;
      logic [31:0] ramp;
   } motion_cmd_t;
endpackage : drive_mode_pkg
`default_nettype wire

// file: testbench/drive_mode_and_homing_control_test.sv
`include "drive_mode_params.svh"
`default_nettype none
module drive_mode_and_homing_control_test
   import drive_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic sys_rst;
   obj_req_t objReq;
   obj_rsp_t objRsp;
   logic [15:0] ctrlWord;
   logic faultDetect, velocityZero, posLimit, negLimit, refSwitch, indexPulse;
   logic [15:0] statusBits;
   logic [7:0] modeActive;
   motion_cmd_t motionCmd;
   logic posLoad;
   logic signed [31:0] posLoadValue;
   logic [15:0] homeErrCode;
   int loadCount = 0;
   logic [31:0] loadVal;
   int miscompares = 0;
   int nChecks = 0;

   always #2 sys_clk = ~sys_clk;

   field_master_model master_u (.sys_clk(sys_clk), .objReq(objReq), .objRsp(objRsp),
      .ctrlWord(ctrlWord));
   drive_mode_and_homing_control dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .objReq(objReq), .objRsp(objRsp), .ctrlWord(ctrlWord), .faultDetect(faultDetect),
      .velocityZero(velocityZero), .posLimit(posLimit), .negLimit(negLimit),
      .refSwitch(refSwitch), .indexPulse(indexPulse), .statusBits(statusBits),
      .modeActive(modeActive), .motionCmd(motionCmd), .posLoad(posLoad),
      .posLoadValue(posLoadValue), .homeErrCode(homeErrCode));

   // The load strobe lasts one cycle, so it is caught here
   always @(posedge sys_clk) begin
      if (posLoad === 1'b1) begin
         loadCount <= loadCount + 1;
         loadVal <= posLoadValue;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
         input logic expRej);
      logic rej;
      logic [31:0] q;
      master_u.access(1'b1, idx, sub, d, rej, q);
      check("write reject", {31'h0, rej}, {31'h0, expRej});
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
         input logic expRej);
      logic rej;
      logic [31:0] q;
      master_u.access(1'b0, idx, sub, 32'h0, rej, q);
      check("read reject", {31'h0, rej}, {31'h0, expRej});
      if (!expRej) check("read data", q, exp);
   endtask : rd

   task automatic settle;
      repeat (2) @(negedge sys_clk);
   endtask : settle

   task automatic test_reset;
      rd(`IDX_HALT_SEL, `SUB_COUNT, 32'h0, 1'b0);
      rd(`IDX_FAULT_SEL, `SUB_COUNT, 32'h0, 1'b0);
      rd(`IDX_MODE_SEL, `SUB_COUNT, 32'h1, 1'b0);
      rd(`IDX_MODE_RB, `SUB_COUNT, 32'h1, 1'b0);
      rd(`IDX_HOME_OFS, `SUB_COUNT, 32'h0, 1'b0);
      rd(`IDX_METHOD, `SUB_COUNT, 32'h1, 1'b0);
      rd(`IDX_SPEEDS, `SUB_SWITCH, 32'h1388, 1'b0);
      rd(`IDX_SPEEDS, `SUB_ZERO, 32'h64, 1'b0);
      rd(`IDX_SPEEDS, `SUB_COUNT, 32'h2, 1'b0);
      rd(`IDX_RAMP, `SUB_COUNT, 32'h186a0, 1'b0);
      check("mode after reset", modeActive, 32'h1);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_refuse;
      logic [7:0] cur;
      logic ok;
      int meth[11] = '{0, 14, 15, 16, 17, 30, 31, 32, 33, 35, 36};
      cur = 8'h01;
      for (int m = 0; m < 9; m++) begin
         ok = (m == 1) || (m == 3) || (m == 4) || (m == 6) || (m == 7);
         wr(`IDX_MODE_SEL, `SUB_COUNT, 32'(m), !ok);
         if (ok) cur = 8'(m);
         settle();
         check("mode active", modeActive, cur);
         rd(`IDX_MODE_RB, `SUB_COUNT, 32'(cur), 1'b0);
      end
      foreach (meth[i]) begin
         ok = (meth[i] >= 1 && meth[i] <= 14) || (meth[i] >= 17 && meth[i] <= 30) ||
            (meth[i] >= 33 && meth[i] <= 35);
         wr(`IDX_METHOD, `SUB_COUNT, 32'(meth[i]), !ok);
      end
      rd(`IDX_METHOD, `SUB_COUNT, 32'd35, 1'b0);
      for (int h = 0; h < 4; h++) wr(`IDX_HALT_SEL, `SUB_COUNT, 32'(h), h == 0 || h == 3);
      rd(`IDX_HALT_SEL, `SUB_COUNT, 32'h2, 1'b0);
      wr(`IDX_FAULT_SEL, `SUB_COUNT, 32'h1, 1'b1);
      wr(`IDX_FAULT_SEL, `SUB_COUNT, 32'h0, 1'b0);
      wr(`IDX_MODE_RB, `SUB_COUNT, 32'h3, 1'b1);
      rd(16'h6062, `SUB_COUNT, 32'h0, 1'b1);
      wr(`IDX_SPEEDS, 8'h03, 32'h10, 1'b1);
      wr(`IDX_HOME_OFS, `SUB_COUNT, 32'hffff_fc18, 1'b0);
      wr(`IDX_MODE_SEL, `SUB_COUNT, 32'h1, 1'b0);
      $display("test_refuse done");
   endtask : test_refuse

   task automatic test_stop;
      wr(`IDX_HALT_SEL, `SUB_COUNT, 32'h1, 1'b0);
      master_u.setCtrl(16'h0100);
      settle();
      check("stop decel", motionCmd.stop, STOP_DECEL);
      wr(`IDX_HALT_SEL, `SUB_COUNT, 32'h2, 1'b0);
      settle();
      check("stop urgent", motionCmd.stop, STOP_URGENT);
      faultDetect = 1'b1;
      settle();
      check("stop coast", motionCmd.stop, STOP_COAST);
      faultDetect = 1'b0;
      master_u.setCtrl(16'h0000);
      settle();
      check("stop none", motionCmd.stop, STOP_NONE);
      $display("test_stop done");
   endtask : test_stop

   task automatic test_home;
      int loads;
      wr(`IDX_MODE_SEL, `SUB_COUNT, 32'h6, 1'b0);
      wr(`IDX_METHOD, `SUB_COUNT, 32'h3, 1'b0);
      settle();
      check("mode homing", modeActive, 32'h6);
      loads = loadCount;
      master_u.setCtrl(16'h0010);
      settle();
      check("homing move", motionCmd.homingMove, 1'b1);
      check("switch speed", motionCmd.speed, 32'h1388);
      check("direction", motionCmd.dirNegative, 1'b1);
      check("attained early", statusBits[`SW_ATTAINED], 1'b0);
      refSwitch = 1'b1;
      settle();
      check("zero speed", motionCmd.speed, 32'h64);
      indexPulse = 1'b1;
      @(negedge sys_clk);
      indexPulse = 1'b0;
      refSwitch = 1'b0;
      settle();
      check("offset loaded", loadCount - loads, 1);
      check("load value", loadVal, 32'hffff_fc18);
      check("attained", statusBits[`SW_ATTAINED], 1'b1);
      check("home reached", statusBits[`SW_TARGET], 1'b1);
      check("move ended", motionCmd.homingMove, 1'b0);
      $display("test_home done");
   endtask : test_home

   task automatic test_abort_halt;
      master_u.setCtrl(16'h0000);
      master_u.setCtrl(16'h0010);
      settle();
      check("restart move", motionCmd.homingMove, 1'b1);
      check("attained cleared", statusBits[`SW_ATTAINED], 1'b0);
      master_u.setCtrl(16'h0000);
      settle();
      check("aborted", motionCmd.homingMove, 1'b0);
      master_u.setCtrl(16'h0010);
      master_u.setCtrl(16'h0110);
      settle();
      check("halt decel", motionCmd.stop, STOP_DECEL);
      check("halt ramp", motionCmd.ramp, 32'h186a0);
      check("halt moving", motionCmd.homingMove, 1'b0);
      check("decelerating", statusBits[`SW_TARGET], 1'b0);
      velocityZero = 1'b1;
      settle();
      check("standstill", statusBits[`SW_TARGET], 1'b1);
      velocityZero = 1'b0;
      master_u.setCtrl(16'h0000);
      $display("test_abort_halt done");
   endtask : test_abort_halt

   task automatic test_fail;
      int loads;
      master_u.setCtrl(16'h0010);
      settle();
      negLimit = 1'b1;
      settle();
      check("error flag", statusBits[`SW_HOME_ERR], 1'b1);
      check("error code", homeErrCode, 32'h1);
      check("not attained", statusBits[`SW_ATTAINED], 1'b0);
      negLimit = 1'b0;
      master_u.setCtrl(16'h0000);
      wr(`IDX_METHOD, `SUB_COUNT, 32'd35, 1'b0);
      loads = loadCount;
      master_u.setCtrl(16'h0010);
      settle();
      check("error cleared", statusBits[`SW_HOME_ERR], 1'b0);
      check("instant home", statusBits[`SW_ATTAINED], 1'b1);
      check("instant load", loadCount - loads, 1);
      master_u.setCtrl(16'h0000);
      wr(`IDX_METHOD, `SUB_COUNT, 32'd18, 1'b0);
      master_u.setCtrl(16'h0010);
      settle();
      check("positive dir", motionCmd.dirNegative, 1'b0);
      check("limit search", statusBits[`SW_ATTAINED], 1'b0);
      loads = loadCount;
      posLimit = 1'b1;
      settle();
      check("limit home", statusBits[`SW_ATTAINED], 1'b1);
      check("limit load", loadCount - loads, 1);
      posLimit = 1'b0;
      master_u.setCtrl(16'h0000);
      $display("test_fail done");
   endtask : test_fail

   task automatic finish_test;
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   initial begin
      sys_rst = 1'b1;
      faultDetect = 1'b0;
      velocityZero = 1'b0;
      posLimit = 1'b0;
      negLimit = 1'b0;
      refSwitch = 1'b0;
      indexPulse = 1'b0;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      test_reset();
      test_refuse();
      test_stop();
      test_home();
      test_abort_halt();
      test_fail();
      finish_test();
   end

   // A few hundred cycles are expected; this allows ample margin
   initial begin
      #20000;
      miscompares++;
      finish_test();
   end
endmodule : drive_mode_and_homing_control_test
`default_nettype wire

// file: testbench/field_master_model.sv
`default_nettype none
module field_master_model
   import drive_mode_pkg::*;
(
   input wire logic sys_clk,
   output obj_req_t objReq,
   input wire obj_rsp_t objRsp,
   output logic [15:0] ctrlWord
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      objReq = '0;
      objReq.data = 32'hffff_ffff;
      ctrlWord = 16'h0000;
   end

   // One-cycle request; idle data is inverted so a stale word never passes
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
         input logic [31:0] wdata, output logic rej, output logic [31:0] rdata);
      int n;
      @(negedge sys_clk);
      objReq.write = wr;
      objReq.read = ~wr;
      objReq.index = idx;
      objReq.sub = sub;
      objReq.data = wdata;
      @(negedge sys_clk);
      objReq.write = 1'b0;
      objReq.read = 1'b0;
      objReq.data = ~wdata;
      n = 0;
      while (objRsp.ack !== 1'b1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      rej = (n < 8) ? objRsp.reject : 1'bx;
      rdata = objRsp.data;
   endtask : access

   task automatic setCtrl(input logic [15:0] v);
      @(negedge sys_clk);
      ctrlWord = v;
   endtask : setCtrl
endmodule : field_master_model
`default_nettype wire
